// ===== rtl/tec_consts.vh
// Constants for the 8-bit timer/event counter: register offsets, field positions, reset values, mode codes.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock, mclk.
`ifndef TEC_CONSTS_VH
`define TEC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TEC_ADDR_COUNT    4'h0
`define TEC_ADDR_CTRL     4'h4
`define TEC_ADDR_IRQCTL   4'h8

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TEC_CTRL_PSC_LSB  0
`define TEC_CTRL_PSC_MSB  2
`define TEC_CTRL_POL_BIT  3
`define TEC_CTRL_RUN_BIT  4
`define TEC_CTRL_MODE_LSB 6
`define TEC_CTRL_MODE_MSB 7
`define TEC_CTRL_RW_MASK  8'hdf

// ----------------------------------------------------------------------
// Interrupt control register fields
// ----------------------------------------------------------------------
`define TEC_IRQ_EN_BIT    0
`define TEC_IRQ_FLAG_BIT  1

// ----------------------------------------------------------------------
// Mode codes, high bit first
// ----------------------------------------------------------------------
`define TEC_MODE_IDLE     2'h0
`define TEC_MODE_EVENT    2'h1
`define TEC_MODE_TIMER    2'h2
`define TEC_MODE_PULSE    2'h3

// ----------------------------------------------------------------------
// Reset values and the full count value
// ----------------------------------------------------------------------
`define TEC_RST_COUNT     8'h00
`define TEC_RST_PRELOAD   8'h00
`define TEC_RST_CTRL      8'h00
`define TEC_COUNT_FULL    8'hff

`endif

// ===== rtl/tec_timer_event_counter.v
// Top of the 8-bit timer/event counter with reload, 3-bit prescaler and three modes.
// Assumes an Avalon-MM master on mclk and an asynchronous count pin that is synchronised here.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`include "tec_consts.vh"

module tec_timer_event_counter #(
  parameter CNT_WIDTH = 8,
  parameter PSC_STAGES = 7
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWritedata,
  input  wire [3:0]  avsByteenable,
  output reg  [31:0] avsReaddata,
  output reg         avsWaitrequest,
  input  wire        countInputPin,
  input  wire        pinDirIsInput,
  input  wire        powerDown,
  output reg         timerIrq,
  output reg         wakeUp
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  reg [CNT_WIDTH-1:0]  count_reg;
  reg [CNT_WIDTH-1:0]  count_next;
  reg [CNT_WIDTH-1:0]  preload_reg;
  reg [7:0]            ctrl_reg;
  reg [7:0]            ctrl_next;
  reg                  irqEn_reg;
  reg                  irqFlag_reg;
  reg                  irqFlag_next;
  reg [PSC_STAGES-1:0] div_reg;
  reg                  pinSync1_reg;
  reg                  pinSync2_reg;
  reg                  pinPrev_reg;
  reg                  measuring_reg;
  reg                  measuring_next;
  reg                  overflow;
  reg                  countEn;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  wire [2:0] prescaleSel  = ctrl_reg[`TEC_CTRL_PSC_MSB:`TEC_CTRL_PSC_LSB];
  wire       edgePolarity = ctrl_reg[`TEC_CTRL_POL_BIT];
  wire       runFlag      = ctrl_reg[`TEC_CTRL_RUN_BIT];
  wire [1:0] modeSel      = ctrl_reg[`TEC_CTRL_MODE_MSB:`TEC_CTRL_MODE_LSB];

  wire modeTimer = (modeSel == `TEC_MODE_TIMER);
  wire modeEvent = (modeSel == `TEC_MODE_EVENT);
  wire modePulse = (modeSel == `TEC_MODE_PULSE);

  // ----------------------------------------------------------------------
  // Bus access decode
  // ----------------------------------------------------------------------
  wire busReq     = avsRead | avsWrite;
  wire busDone    = busReq & ~avsWaitrequest;
  wire hitCount   = (avsAddress == `TEC_ADDR_COUNT);
  wire hitCtrl    = (avsAddress == `TEC_ADDR_CTRL);
  wire hitIrq     = (avsAddress == `TEC_ADDR_IRQCTL);
  wire lane0      = avsByteenable[0];
  wire wrCount    = busDone & avsWrite & hitCount & lane0;
  wire wrCtrl     = busDone & avsWrite & hitCtrl & lane0;
  wire wrIrq      = busDone & avsWrite & hitIrq & lane0;

  // Counting pauses for the whole access to the count register.
  wire countInhibit = busReq & hitCount;

  // ----------------------------------------------------------------------
  // Avalon slave: one wait cycle, then the access completes
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h0000_0000;
    end else begin
      avsWaitrequest <= ~(busReq & avsWaitrequest);
      if (avsRead & avsWaitrequest) begin
        if (hitCount) begin
          avsReaddata <= {{(32-CNT_WIDTH){1'b0}}, count_reg};
        end else if (hitCtrl) begin
          avsReaddata <= {24'h00_0000, ctrl_reg};
        end else if (hitIrq) begin
          avsReaddata <= {30'h0000_0000, irqFlag_reg, irqEn_reg};
        end else begin
          avsReaddata <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler: code n gives a tick every 2**n mclk cycles
  // ----------------------------------------------------------------------
  wire [PSC_STAGES-1:0] divMask = ~({PSC_STAGES{1'b1}} << prescaleSel);
  // The tick marks the falling edge of the divided clock.
  wire prescaleTick = ((div_reg & divMask) == divMask);

  always @(posedge mclk) begin
    if (srst) begin
      div_reg <= {PSC_STAGES{1'b0}};
    end else begin
      div_reg <= div_reg + {{(PSC_STAGES-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // Count pin synchroniser and edge detect
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
      pinPrev_reg  <= 1'b0;
    end else begin
      pinSync1_reg <= countInputPin;
      pinSync2_reg <= pinSync1_reg;
      pinPrev_reg  <= pinSync2_reg;
    end
  end

  wire pinRise    = pinSync2_reg & ~pinPrev_reg;
  wire pinFall    = ~pinSync2_reg & pinPrev_reg;
  wire pinUsed    = (modeEvent | modePulse) & pinDirIsInput;
  wire eventEdge  = edgePolarity ? pinFall : pinRise;
  wire pulseStart = edgePolarity ? pinRise : pinFall;
  wire pulseEnd   = edgePolarity ? pinFall : pinRise;

  // ----------------------------------------------------------------------
  // Pulse width measurement window
  // ----------------------------------------------------------------------
  wire pulseEndHit = modePulse & runFlag & measuring_reg & pinUsed & pulseEnd;

  always @* begin
    measuring_next = measuring_reg;
    if (~runFlag | ~modePulse | ~pinUsed) begin
      measuring_next = 1'b0;
    end else if (pulseEnd) begin
      measuring_next = 1'b0;
    end else if (pulseStart) begin
      measuring_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Count qualification
  // ----------------------------------------------------------------------
  always @* begin
    countEn = 1'b0;
    if (runFlag & ~countInhibit) begin
      if (modeTimer) begin
        countEn = prescaleTick & ~powerDown;
      end else if (modeEvent) begin
        countEn = pinUsed & eventEdge;
      end else if (modePulse) begin
        countEn = measuring_reg & prescaleTick & ~powerDown;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Counter, preload and overflow
  // ----------------------------------------------------------------------
  always @* begin
    overflow   = 1'b0;
    count_next = count_reg;
    if (wrCount & ~runFlag) begin
      count_next = avsWritedata[CNT_WIDTH-1:0];
    end else if (countEn) begin
      if (count_reg == `TEC_COUNT_FULL) begin
        overflow   = 1'b1;
        count_next = preload_reg;
      end else begin
        count_next = count_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      count_reg     <= `TEC_RST_COUNT;
      preload_reg   <= `TEC_RST_PRELOAD;
      measuring_reg <= 1'b0;
    end else begin
      count_reg     <= count_next;
      measuring_reg <= measuring_next;
      if (wrCount) begin
        preload_reg <= avsWritedata[CNT_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register: a software write wins over the hardware run clear
  // ----------------------------------------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    if (wrCtrl) begin
      ctrl_next = avsWritedata[7:0] & `TEC_CTRL_RW_MASK;
    end else if (pulseEndHit) begin
      ctrl_next[`TEC_CTRL_RUN_BIT] = 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= `TEC_RST_CTRL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt request flag, enable, and wake-up
  // ----------------------------------------------------------------------
  always @* begin
    irqFlag_next = irqFlag_reg;
    if (wrIrq) begin
      irqFlag_next = avsWritedata[`TEC_IRQ_FLAG_BIT];
    end
    if (overflow) begin
      irqFlag_next = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      irqEn_reg   <= 1'b0;
      irqFlag_reg <= 1'b0;
      timerIrq    <= 1'b0;
      wakeUp      <= 1'b0;
    end else begin
      irqFlag_reg <= irqFlag_next;
      if (wrIrq) begin
        irqEn_reg <= avsWritedata[`TEC_IRQ_EN_BIT];
      end
      timerIrq <= irqFlag_reg & irqEn_reg;
      wakeUp   <= overflow;
    end
  end

endmodule // tec_timer_event_counter

// ===== testbench/tec_checker_sva.sv
// Checker for the bus handshake and the output pins of the timer/event counter.
// Assumes it is bound to tec_timer_event_counter and sees only that module's ports.
module tec_checker_sva (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [3:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReaddata,
  input wire logic        avsWaitrequest,
  input wire logic        timerIrq,
  input wire logic        wakeUp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire req = avsRead | avsWrite;
  wire rdDone = avsRead & ~avsWaitrequest;
  wire mapped = avsAddress == 4'h0 || avsAddress == 4'h4 || avsAddress == 4'h8;
  wire irqWr = avsWrite & ~avsWaitrequest & (avsAddress == 4'h8);

  a_wait_answer: assert property ($rose(req) |=> !avsWaitrequest) else $error("No answer.");
  a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest) else $error("Long answer.");
  a_idle_wait: assert property (!req |-> avsWaitrequest) else $error("Answer while idle.");
  a_unmapped_zero: assert property (rdDone && !mapped |-> avsReaddata == 32'h0) else $error("Unmapped data.");
  a_upper_zero: assert property (rdDone |-> avsReaddata[31:8] == 24'h0) else $error("Upper bits set.");
  a_ctrl_bit5: assert property (rdDone && avsAddress == 4'h4 |-> !avsReaddata[5]) else $error("Bit 5 set.");
  a_wake_pulse: assert property (wakeUp |=> !wakeUp) else $error("Wake pulse too long.");
  a_irq_cause: assert property ($rose(timerIrq) |-> $past(wakeUp) || $past(irqWr, 2)) else $error("Stray irq.");
  a_reset_quiet: assert property ($fell(srst) |-> !timerIrq && !wakeUp && avsWaitrequest) else $error("Reset.");
endmodule // tec_checker_sva

bind tec_timer_event_counter tec_checker_sva tec_checker_sva_inst (.mclk(mclk), .srst(srst),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest), .timerIrq(timerIrq), .wakeUp(wakeUp));

// ===== testbench/tec_pulse_source.sv
// External pulse and event source for the count input pin.
// Assumes its tasks are called just after a rising edge of mclk.
module tec_pulse_source (
  input  wire logic mclk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  task automatic setLevel(input logic lvl);
    @(posedge mclk) pin <= lvl;
    repeat (8) @(posedge mclk);
  endtask
  // One pulse at the active level, then a quiet gap so each edge is seen alone.
  task automatic pulse(input logic act, input int width);
    @(posedge mclk) pin <= act;
    repeat (width) @(posedge mclk);
    pin <= ~act;
    repeat (8) @(posedge mclk);
  endtask
endmodule // tec_pulse_source

// ===== testbench/tb_tec_timer_event_counter.sv
// Self-checking bench for the timer/event counter.
// Assumes the Avalon slave answers after one wait cycle and the pin source model.
`include "tec_consts.vh"
module tb_tec_timer_event_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, srst = 1, avsRead = 0, avsWrite = 0, pinDirIsInput = 1, powerDown = 0;
  logic [3:0] avsAddress = 0, avsByteenable = 4'h1;
  logic [31:0] avsWritedata = 0, avsReaddata;
  logic avsWaitrequest, countInputPin, timerIrq, wakeUp;
  int failures = 0, comparisons = 0, wakes = 0, cycles = 0;
  logic [7:0] q, keep;
  always #12.5 mclk = ~mclk;
  tec_timer_event_counter tec_timer_event_counter_inst (.mclk(mclk), .srst(srst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .countInputPin(countInputPin),
    .pinDirIsInput(pinDirIsInput), .powerDown(powerDown), .timerIrq(timerIrq), .wakeUp(wakeUp));
  tec_pulse_source tec_pulse_source_inst (.mclk(mclk), .pin(countInputPin));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (wakeUp === 1'b1) wakes++;
    if (cycles == 30000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic inRange(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    check({7'h0, got >= lo && got <= hi}, 8'h01);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avsAddress <= a;
    avsWritedata <= {24'h0, d};
    avsWrite <= w;
    avsRead <= ~w;
    do @(posedge mclk); while (avsWaitrequest !== 1'b0);
    q = avsReaddata[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    rd(`TEC_ADDR_COUNT); check(q, 8'h00);
    rd(`TEC_ADDR_IRQCTL); check(q, 8'h00);
    rd(4'hc); check(q, 8'h00);
    bus(1, `TEC_ADDR_CTRL, 8'hff);
    rd(`TEC_ADDR_CTRL); check(q, 8'hdf);
    bus(1, `TEC_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_event();
    bus(1, `TEC_ADDR_COUNT, 8'hfd);
    rd(`TEC_ADDR_COUNT); check(q, 8'hfd);
    bus(1, `TEC_ADDR_IRQCTL, 8'h01);
    powerDown <= 1'b1;
    bus(1, `TEC_ADDR_CTRL, 8'h50);
    repeat (2) tec_pulse_source_inst.pulse(1'b1, 8);
    rd(`TEC_ADDR_COUNT); check(q, 8'hff);
    bus(1, `TEC_ADDR_COUNT, 8'h10);
    rd(`TEC_ADDR_COUNT); check(q, 8'hff);
    tec_pulse_source_inst.pulse(1'b1, 8);
    rd(`TEC_ADDR_COUNT); check(q, 8'h10);
    rd(`TEC_ADDR_IRQCTL); check(q, 8'h03);
    check({7'h0, timerIrq}, 8'h01);
    check(wakes[7:0], 8'h01);
    bus(1, `TEC_ADDR_CTRL, 8'h58);
    tec_pulse_source_inst.pulse(1'b1, 8);
    rd(`TEC_ADDR_COUNT); check(q, 8'h11);
    pinDirIsInput <= 1'b0;
    tec_pulse_source_inst.pulse(1'b1, 8);
    rd(`TEC_ADDR_COUNT); check(q, 8'h11);
    pinDirIsInput <= 1'b1;
    bus(1, `TEC_ADDR_IRQCTL, 8'h02);
    @(posedge mclk);
    check({7'h0, timerIrq}, 8'h00);
    powerDown <= 1'b0;
    bus(1, `TEC_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_pulse();
    tec_pulse_source_inst.setLevel(1'b1);
    bus(1, `TEC_ADDR_COUNT, 8'h00);
    bus(1, `TEC_ADDR_CTRL, 8'hd0);
    tec_pulse_source_inst.pulse(1'b0, 20);
    rd(`TEC_ADDR_CTRL); check(q, 8'hc0);
    rd(`TEC_ADDR_COUNT); inRange(q, 8'h13, 8'h15);
    keep = q;
    tec_pulse_source_inst.pulse(1'b0, 20);
    rd(`TEC_ADDR_COUNT); check(q, keep);
    tec_pulse_source_inst.setLevel(1'b0);
    bus(1, `TEC_ADDR_COUNT, 8'h00);
    bus(1, `TEC_ADDR_CTRL, 8'hd0);
    repeat (20) @(posedge mclk);
    rd(`TEC_ADDR_COUNT); check(q, 8'h00);
    bus(1, `TEC_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_timer();
    for (int n = 0; n < 8; n++) begin
      bus(1, `TEC_ADDR_COUNT, 8'h00);
      bus(1, `TEC_ADDR_CTRL, 8'h90 | n[7:0]);
      repeat (32 << n) @(posedge mclk);
      bus(1, `TEC_ADDR_CTRL, 8'h80);
      rd(`TEC_ADDR_COUNT); inRange(q, 8'h1e, 8'h24);
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_event();
    t_pulse();
    t_timer();
    wrap_up();
  end
endmodule // tb_tec_timer_event_counter
